// [hw/ppchk_top.sv]
// page protection and reference/change history checker
//
// Overview of operation
// - store, external out, block zero, block allocate set referenced and changed.
// - icache invalidate, touches, block store and flush never set changed.
// - whenever changed is set optionally, referenced is set too.
// - block allocate leaving block unmodified sets neither flag.
// - flag updates may be posted after the access completes.
// - memory barrier completes only after pending flag updates drain.
// - invalidate barrier completes only after hit access and updates drain.
// - key is supervisor key bit in privilege 0, user key bit in 1.
// - protect 10 allows everything; protect 11 faults every write.
// - key 1 with protect 00 faults every access.
// - key 1 with protect 01 allows reads, faults writes.
// - violation raises fetch fault for fetches, data fault otherwise.
// - data violation sets syndrome bit 4, plus bit 6 on stores.
// - fetch protection violation sets saved state bit 4; here a fetch from a no-execute segment sets only bit 3, never bit 4.
// - fetch from no-execute segment sets saved state bit 3.
// - refused store never sets changed; referenced may be set.
// - segment key registers writable only in supervisor state.
// - highest priority matching scenario decides the flags.
// - no-execute violation sets neither flag.
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "ppchk_defines.svh"
module ppchk_top #(
   parameter int PEND_W = 4
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire ppchk_pkg::ppchk_req_type req,
   input wire logic upd_done,
   input wire logic barrier_req,
   input wire logic inv_barrier_req,
   input wire logic inv_hit,
   output ppchk_pkg::ppchk_rsp_type rsp,
   output logic barrier_done,
   output logic inv_barrier_done
);
   import ppchk_pkg::*;

   logic [31:0] ctrl;
   logic [31:0] seg;
   logic [7:0] last_synd;
   logic [7:0] last_srr;
   logic [PEND_W-1:0] pend;
   ppchk_sync_type sync_state;
   logic sync_is_inv;
   logic ap_valid;
   logic ap_write;
   logic [7:0] ap_addr;
   logic privilege_state_bit;
   logic supervisor_key_bit;
   logic user_key_bit;
   logic no_exec;
   logic key;
   logic is_write;
   logic is_fetch;
   logic violation;
   logic nx_fault;
   logic next_ref;
   logic next_chg;
   logic upd_post;
   logic [PEND_W-1:0] next_pend;
   ppchk_rsp_type next_rsp;
   ppchk_sync_type next_sync_state;
   logic next_sync_is_inv;
   logic drained;
   logic data_viol;
   logic fetch_viol;
   logic [4:0] wr_hit;
   logic [4:0] rd_hit;

   // ctrl[0] privilege state, seg[0] supervisor key, seg[1] user key, seg[2] no-execute
   assign privilege_state_bit = ctrl[0];
   assign supervisor_key_bit = seg[0];
   assign user_key_bit = seg[1];
   assign no_exec = seg[2];

   function automatic logic write_like(input ppchk_op_type op);
      return op inside {op_store, op_ext_out, op_blk_zero, op_blk_alloc, op_blk_inv};
   endfunction

   // one decode serves the write path and the read path
   function automatic logic [4:0] reg_hit(input logic [7:0] a);
      logic [4:0] h;
      h = 5'h00;
      if (a == `PPCHK_ADDR_CTRL) begin
         h[0] = 1'b1;
      end else if (a == `PPCHK_ADDR_SEG) begin
         h[1] = 1'b1;
      end else if (a == `PPCHK_ADDR_SYND) begin
         h[2] = 1'b1;
      end else if (a == `PPCHK_ADDR_STAT) begin
         h[3] = 1'b1;
      end else if (a == `PPCHK_ADDR_PEND) begin
         h[4] = 1'b1;
      end
      return h;
   endfunction

   function automatic logic prot_fault(input logic k, input logic [1:0] pp, input logic wr);
      logic f;
      f = 1'b0;
      if (pp == `PPCHK_PP_ALL) begin
         f = 1'b0;
      end else if (pp == `PPCHK_PP_RO) begin
         f = wr;
      end else if (k && pp == `PPCHK_PP_NONE) begin
         f = 1'b1;
      end else if (k && pp == `PPCHK_PP_SWO) begin
         f = wr;
      end else begin
         f = 1'b0;
      end
      return f;
   endfunction

   assign key = privilege_state_bit ? user_key_bit : supervisor_key_bit;
   assign is_fetch = req.op == op_fetch;
   assign is_write = write_like(req.op);
   assign nx_fault = is_fetch && no_exec;
   assign violation = prot_fault(key, req.page_protect_bits, is_write);
   assign data_viol = req.valid && !is_fetch && violation;
   assign fetch_viol = req.valid && is_fetch && (nx_fault || violation);
   assign wr_hit = reg_hit(ap_addr);
   assign rd_hit = reg_hit(haddr[7:0]);

   // scenario priority: no-execute, then page protection, then per-op scenarios
   always_comb begin
      next_ref = 1'b0;
      next_chg = 1'b0;
      if (nx_fault) begin
         next_ref = 1'b0;
         next_chg = 1'b0;
      end else if (violation) begin
         next_ref = 1'b1;
         next_chg = 1'b0;
      end else begin
         case (req.op)
            op_store, op_ext_out, op_blk_zero: begin
               next_ref = 1'b1;
               next_chg = 1'b1;
            end
            op_blk_alloc: begin
               next_ref = req.block_modified;
               next_chg = req.block_modified;
            end
            op_icache_inv, op_touch, op_touch_st, op_blk_store, op_blk_flush: begin
               next_ref = 1'b1;
               next_chg = 1'b0;
            end
            op_blk_inv: begin
               // optional change is taken, so referenced must follow
               next_chg = 1'b1;
               next_ref = next_chg;
            end
            default: begin
               next_ref = 1'b1;
               next_chg = 1'b0;
            end
         endcase
      end
   end

   // whole response built here so a single register stage carries it out
   always_comb begin
      next_rsp = '0;
      next_rsp.valid = req.valid;
      next_rsp.instruction_fetch_fault = fetch_viol;
      next_rsp.data_fault = data_viol;
      next_rsp.set_ref = req.valid && next_ref;
      next_rsp.set_chg = req.valid && next_chg;
      if (data_viol) begin
         next_rsp.data_fault_syndrome_reg[`PPCHK_SYND_PROT] = 1'b1;
         next_rsp.data_fault_syndrome_reg[`PPCHK_SYND_STORE] = is_write;
      end
      if (req.valid && nx_fault) begin
         next_rsp.saved_machine_state_reg[`PPCHK_SRR_NOEXEC] = 1'b1;
      end else if (fetch_viol) begin
         next_rsp.saved_machine_state_reg[`PPCHK_SRR_PROT] = 1'b1;
      end
   end

   // response registered; flag writeback is posted to the table walker
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rsp <= '0;
      end else begin
         rsp <= next_rsp;
      end
   end

   // count of posted flag updates not yet written to the table
   assign upd_post = rsp.valid && (rsp.set_ref || rsp.set_chg);
   always_comb begin
      next_pend = pend;
      if (upd_post && !(upd_done && pend != '0)) begin
         next_pend = pend + PEND_W'(1);
      end else if (!upd_post && upd_done && pend != '0) begin
         next_pend = pend - PEND_W'(1);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend <= '0;
      end else begin
         pend <= next_pend;
      end
   end

   assign drained = pend == '0 && !upd_post && !req.valid && !rsp.valid;

   // barriers hold off until every posted access and update is performed
   always_comb begin
      next_sync_state = sync_state;
      next_sync_is_inv = sync_is_inv;
      case (sync_state)
         sync_idle: begin
            if (barrier_req) begin
               next_sync_state = sync_drain;
               next_sync_is_inv = 1'b0;
            end else if (inv_barrier_req) begin
               next_sync_state = sync_drain;
               next_sync_is_inv = 1'b1;
            end
         end
         sync_drain: begin
            if (drained) begin
               next_sync_state = sync_idle;
            end
         end
         default: next_sync_state = sync_idle;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_state <= sync_idle;
         sync_is_inv <= 1'b0;
      end else begin
         sync_state <= next_sync_state;
         sync_is_inv <= next_sync_is_inv;
      end
   end

   // done pulses last one cycle; the waiting core retires its barrier on it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         barrier_done <= 1'b0;
         inv_barrier_done <= 1'b0;
      end else begin
         barrier_done <= sync_state == sync_drain && drained && !sync_is_inv;
         inv_barrier_done <= sync_state == sync_drain && drained && sync_is_inv;
      end
   end

   // ahb-lite slave, zero wait states, always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid <= 1'b0;
         ap_write <= 1'b0;
         ap_addr <= '0;
      end else if (hready) begin
         ap_valid <= hsel && htrans[1];
         ap_write <= hwrite;
         ap_addr <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= `PPCHK_CTRL_RST;
         seg <= `PPCHK_SEG_RST;
      end else if (ap_valid && ap_write) begin
         if (wr_hit[0]) begin
            ctrl <= {31'h0, hwdata[0]};
         end else if (wr_hit[1] && !privilege_state_bit) begin
            seg <= {29'h0, hwdata[2:0]};
         end
      end
   end

   // last fault syndromes kept for software; only the newest fault survives
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_synd <= '0;
      end else begin
         if (rsp.data_fault) begin
            last_synd <= rsp.data_fault_syndrome_reg;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_srr <= '0;
      end else begin
         if (rsp.instruction_fetch_fault) begin
            last_srr <= rsp.saved_machine_state_reg;
         end
      end
   end

   // read data registered in the address phase so it stands in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         if (rd_hit[0]) begin
            hrdata <= ctrl;
         end else if (rd_hit[1]) begin
            hrdata <= seg;
         end else if (rd_hit[2]) begin
            hrdata <= {24'h0, last_synd};
         end else if (rd_hit[3]) begin
            hrdata <= {24'h0, last_srr};
         end else if (rd_hit[4]) begin
            hrdata <= {{(32 - PEND_W){1'b0}}, pend};
         end else begin
            hrdata <= '0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
endmodule

// [hw/ppchk_defines.svh]
// offsets, field positions and reset values for the page protection checker
`ifndef PPCHK_DEFINES_SVH
`define PPCHK_DEFINES_SVH
`define PPCHK_ADDR_CTRL 8'h00
`define PPCHK_ADDR_SEG 8'h04
`define PPCHK_ADDR_SYND 8'h08
`define PPCHK_ADDR_STAT 8'h0c
`define PPCHK_ADDR_PEND 8'h10
`define PPCHK_SYND_PROT 4
`define PPCHK_SYND_STORE 6
`define PPCHK_SRR_NOEXEC 3
`define PPCHK_SRR_PROT 4
`define PPCHK_PP_ALL 2'b10
`define PPCHK_PP_RO 2'b11
`define PPCHK_PP_NONE 2'b00
`define PPCHK_PP_SWO 2'b01
`define PPCHK_CTRL_RST 32'h0000_0000
`define PPCHK_SEG_RST 32'h0000_0000
`endif

// [hw/ppchk_pkg.sv]
// types for the page protection checker
package ppchk_pkg;
   typedef enum logic [3:0] {
      op_fetch,
      op_load,
      op_store,
      op_ext_out,
      op_blk_zero,
      op_blk_alloc,
      op_icache_inv,
      op_touch,
      op_touch_st,
      op_blk_store,
      op_blk_flush,
      op_blk_inv
   } ppchk_op_type;
   typedef struct packed {
      logic valid;
      ppchk_op_type op;
      logic [1:0] page_protect_bits;
      logic block_modified;
   } ppchk_req_type;
   typedef struct packed {
      logic valid;
      logic instruction_fetch_fault;
      logic data_fault;
      logic set_ref;
      logic set_chg;
      logic [7:0] data_fault_syndrome_reg;
      logic [7:0] saved_machine_state_reg;
   } ppchk_rsp_type;
   typedef enum {
      sync_idle,
      sync_drain
   } ppchk_sync_type;
endpackage

// [tb/ppchk_checker.sv]
// port assertions for the page protection checker
`timescale 1ns/1ps
module ppchk_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire ppchk_pkg::ppchk_req_type req,
   input wire logic upd_done,
   input wire logic barrier_req,
   input wire ppchk_pkg::ppchk_rsp_type rsp,
   input wire logic barrier_done,
   input wire logic inv_barrier_done
);
   import ppchk_pkg::*;
   logic [7:0] pend;
   // own copy of posted updates still owed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend <= 8'h00;
      end else begin
         pend <= pend + 8'(rsp.valid && (rsp.set_ref || rsp.set_chg)) - 8'(upd_done);
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_fault_kind: assert property (rsp.instruction_fetch_fault |->
      $past(req.op) == op_fetch && !rsp.data_fault) else $error("fault kind");
   a_chg_has_ref: assert property (rsp.valid && rsp.set_chg |-> rsp.set_ref)
      else $error("chg without ref");
   a_refused_chg: assert property (rsp.data_fault |-> !rsp.set_chg) else $error("chg");
   a_synd_bits: assert property (rsp.data_fault |-> rsp.data_fault_syndrome_reg[4] &&
      ($past(req.op) != op_store || rsp.data_fault_syndrome_reg[6])) else $error("synd");
   a_fetch_bits: assert property (rsp.instruction_fetch_fault |->
      rsp.saved_machine_state_reg[3] != rsp.saved_machine_state_reg[4]) else $error("srr");
   a_noexec_flags: assert property (rsp.saved_machine_state_reg[3] |->
      !rsp.set_ref && !rsp.set_chg) else $error("noexec flags");
   a_touch_no_chg: assert property (req.valid && req.op inside {op_icache_inv, op_touch,
      op_touch_st, op_blk_store, op_blk_flush} |=> !rsp.set_chg) else $error("touch chg");
   a_alloc_clean: assert property (req.valid && req.op == op_blk_alloc &&
      req.page_protect_bits == 2'b10 && !req.block_modified |=>
      rsp.valid && !rsp.set_ref && !rsp.set_chg) else $error("alloc");
   a_pp_open: assert property (req.valid && req.page_protect_bits == 2'b10 &&
      req.op != op_fetch |=> !rsp.data_fault) else $error("pp open");
   a_bar_drained: assert property (barrier_done |-> pend == 8'h00) else $error("bar");
   a_inv_drained: assert property (inv_barrier_done |-> pend == 8'h00) else $error("inv");
   a_bar_late: assert property (barrier_req |=> !barrier_done) else $error("bar early");
   cover property (rsp.data_fault);
   cover property (rsp.saved_machine_state_reg[3]);
   cover property (barrier_done);
endmodule
bind ppchk_top ppchk_checker chk_u (.hclk(hclk), .hresetn(hresetn), .req(req),
   .upd_done(upd_done), .barrier_req(barrier_req), .rsp(rsp),
   .barrier_done(barrier_done), .inv_barrier_done(inv_barrier_done));

// [tb/ppchk_walker.sv]
// table walker model that retires posted flag updates
`timescale 1ns/1ps
module ppchk_walker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire ppchk_pkg::ppchk_rsp_type rsp,
   input wire logic [3:0] lat,
   output logic upd_done
);
   import ppchk_pkg::*;
   logic [7:0] owed;
   logic [3:0] wait_cnt;
   logic go;
   assign go = (owed != 8'h00) && (wait_cnt == lat);
   // updates land late, lat+1 cycles apart
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         owed <= 8'h00;
         wait_cnt <= 4'h0;
         upd_done <= 1'b0;
      end else begin
         upd_done <= go;
         wait_cnt <= (owed == 8'h00 || go) ? 4'h0 : wait_cnt + 4'h1;
         owed <= owed + 8'(rsp.valid && (rsp.set_ref || rsp.set_chg)) - 8'(go);
      end
   end
endmodule

// [tb/ppchk_tb_top.sv]
// self-checking bench for the page protection checker
`timescale 1ns/1ps
`include "ppchk_defines.svh"
module ppchk_tb_top;
   import ppchk_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, upd_done, inv_hit;
   logic barrier_req, inv_barrier_req, barrier_done, inv_barrier_done, priv;
   logic [31:0] haddr, hwdata, hrdata, rd, seed, st;
   logic [1:0] htrans;
   logic [2:0] hsize, seg;
   logic [3:0] lat;
   logic [7:0] exp_synd, exp_srr;
   ppchk_req_type req;
   ppchk_rsp_type rsp, m;
   ppchk_rsp_type exq[$], mq[$];
   int fail_count, num_checks, k;
   assign hready = hreadyout;
   ppchk_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req(req), .upd_done(upd_done),
      .barrier_req(barrier_req), .inv_barrier_req(inv_barrier_req), .inv_hit(inv_hit),
      .rsp(rsp), .barrier_done(barrier_done), .inv_barrier_done(inv_barrier_done));
   ppchk_walker walk_u (.hclk(hclk), .hresetn(hresetn), .rsp(rsp), .lat(lat),
      .upd_done(upd_done));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask
   // caller holds req between back-to-back calls and clears it after
   task automatic acc(input ppchk_op_type op, input logic [1:0] pp, input logic bm);
      logic key, wr, v, f;
      ppchk_rsp_type e, mk;
      key = priv ? seg[1] : seg[0];
      wr = op inside {op_store, op_ext_out, op_blk_zero, op_blk_alloc, op_blk_inv};
      f = op == op_fetch;
      v = (key && pp == 2'b00) || (wr && (pp == 2'b11 || (key && pp == 2'b01)));
      e = '0;
      mk = '1;
      e.valid = 1'b1;
      if (f && seg[2]) begin
         e.instruction_fetch_fault = 1'b1;
         e.saved_machine_state_reg[3] = 1'b1;
         exp_srr = e.saved_machine_state_reg;
      end else if (v) begin
         mk.set_ref = 1'b0; // referenced is optional here
         e.instruction_fetch_fault = f;
         e.data_fault = !f;
         e.saved_machine_state_reg[4] = f;
         e.data_fault_syndrome_reg[4] = !f;
         e.data_fault_syndrome_reg[6] = wr;
         if (f) begin
            exp_srr = e.saved_machine_state_reg;
         end else begin
            exp_synd = e.data_fault_syndrome_reg;
         end
      end else begin
         e.set_ref = !(op == op_blk_alloc && !bm);
         e.set_chg = wr && e.set_ref;
      end
      exq.push_back(e);
      mq.push_back(mk);
      req <= {1'b1, op, pp, bm};
      @(posedge hclk);
   endtask
   always @(posedge hclk) begin
      if (rsp.valid === 1'b1) begin
         if (exq.size() == 0) begin
            check("rsp extra", 32'h1, 32'h0);
         end else begin
            m = mq.pop_front();
            check("rsp", 32'(rsp & m), 32'(exq.pop_front() & m));
         end
      end
   end
   initial begin
      #500us;
      fail_count++;
      end_sim;
   end
   initial begin
      {hresetn, hwrite, htrans, haddr, hwdata, barrier_req, inv_barrier_req} = '0;
      {req, inv_hit, lat, priv, seg, fail_count, num_checks, exp_synd, exp_srr} = '0;
      hsel = 1'b1;
      hsize = 3'h2;
      seed = 32'd79;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1'b0, 32'h20, 32'h0);
      check("unmapped", rd, 32'h0);
      for (int i = 0; i < 48; i++) begin
         seed = xs(seed);
         st = seed;
         priv = st[3];
         seg = st[2:0];
         ahb(1'b1, `PPCHK_ADDR_CTRL, 32'h0);
         ahb(1'b1, `PPCHK_ADDR_SEG, {29'h0, seg});
         ahb(1'b1, `PPCHK_ADDR_CTRL, {31'h0, priv});
         ahb(1'b1, `PPCHK_ADDR_SEG, {29'h0, ~seg});
         ahb(1'b0, `PPCHK_ADDR_SEG, 32'h0);
         if (!priv) seg = ~seg;
         check("seg", rd, {29'h0, seg});
         lat <= st[7:4];
         for (int j = 0; j < 12; j++) begin
            seed = xs(seed);
            acc(ppchk_op_type'(seed[3:0] % 12), seed[5:4], seed[6]);
         end
         req <= '0;
         barrier_req <= st[8];
         inv_barrier_req <= !st[8];
         inv_hit <= st[9];
         @(posedge hclk);
         barrier_req <= 1'b0;
         inv_barrier_req <= 1'b0;
         for (k = 0; k < 400 && barrier_done !== 1'b1 && inv_barrier_done !== 1'b1; k++)
            @(posedge hclk);
         check("done", 32'(k < 400), 32'h1);
         check("done kind", {31'h0, barrier_done}, {31'h0, st[8]});
         ahb(1'b0, `PPCHK_ADDR_PEND, 32'h0);
         check("pend", rd, 32'h0);
         ahb(1'b0, `PPCHK_ADDR_SYND, 32'h0);
         check("synd", rd, {24'h0, exp_synd});
         ahb(1'b0, `PPCHK_ADDR_STAT, 32'h0);
         check("srr", rd, {24'h0, exp_srr});
      end
      end_sim;
   end
endmodule
